// ==== lvd_pkg.sv ====
package lvd_pkg;
	// Register map
	localparam logic [15:0] CTRL_ADDR        = 16'hFFBE;
	localparam logic [7:0]  CTRL_RESET       = 8'h00;
	localparam int          ENABLE_BIT       = 7;
	localparam int          SELECT_BIT       = 2;
	localparam int          MODE_BIT         = 1;
	localparam int          FLAG_BIT         = 0;
	localparam logic [7:0]  CTRL_WMASK       = 8'h86;
	// Timing at the 100 MHz system clock
	localparam int          CLK_MHZ          = 100;
	localparam int          MIN_PULSE_US     = 200;
	localparam int          MIN_PULSE_CYCLES = MIN_PULSE_US * CLK_MHZ;

	typedef struct packed {
		logic enable;
		logic select;
		logic mode;
	} ctrl_s;
endpackage : lvd_pkg

// ==== low_voltage_detect_control.sv ====
// Function
// - Enable bit one starts the comparator; zero disables detection.
// - Flag reads zero at or above threshold, or when detection is off.
// - Flag reads one when selected voltage is below its threshold.
// - Mode one: reset while low; mode zero: interrupt on each crossing.
// - Non-detector resets clear the register; detector reset keeps its control bits but clears the flag.
// - Flag bit 0 is read-only; writes do not alter it.
// - Flag sets only after below-threshold lasts the minimum pulse width.
module low_voltage_detect_control #(
	parameter int PULSE_CYCLES = lvd_pkg::MIN_PULSE_CYCLES
) (
	// Clock and resets
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        detector_reset,
	// Register port
	input  wire logic [15:0] addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	// Analog comparator side
	output logic             comparator_on,
	output logic             source_select,
	input  wire logic        supply_low,
	input  wire logic        pin_low,
	// Responses
	output logic             lvd_reset_req,
	output logic             lvd_irq
);
	// Low-pulse counter is only 20 bits wide
	if (PULSE_CYCLES < 1 || PULSE_CYCLES > 1000000) begin : g_bad_pulse
		$error("PULSE_CYCLES out of range");
	end

	lvd_pkg::ctrl_s ctrl;
	logic           low_flag;
	logic [1:0]     sync_supply;
	logic [1:0]     sync_pin;
	logic           sel_low;
	logic [19:0]    low_count;
	logic           next_flag;
	logic           flag_d;
	logic [7:0]     read_word;
	logic           ctrl_hit_wr;
	logic           ctrl_hit_rd;

	// Register hits on the plain port
	assign ctrl_hit_wr = wr && (addr == lvd_pkg::CTRL_ADDR);
	assign ctrl_hit_rd = rd && (addr == lvd_pkg::CTRL_ADDR);

	always_ff @(posedge mclk) begin
		if (rst && !detector_reset) begin
			ctrl <= '0;
		end else if (!rst && ctrl_hit_wr) begin
			ctrl.enable <= wdata[lvd_pkg::ENABLE_BIT];
			ctrl.select <= wdata[lvd_pkg::SELECT_BIT];
			ctrl.mode   <= wdata[lvd_pkg::MODE_BIT];
		end
	end

	assign comparator_on = ctrl.enable;
	assign source_select = ctrl.select;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sync_supply <= 2'h0;
			sync_pin    <= 2'h0;
		end else begin
			sync_supply <= {sync_supply[0], supply_low};
			sync_pin    <= {sync_pin[0], pin_low};
		end
	end

	assign sel_low = ctrl.select ? sync_pin[1] : sync_supply[1];

	always_ff @(posedge mclk) begin
		if (rst || !ctrl.enable || !sel_low)
			low_count <= 20'h00000;
		else if (low_count < 20'(PULSE_CYCLES))
			low_count <= low_count + 20'h00001;
	end

	always_comb begin
		next_flag = ctrl.enable && sel_low &&
			(low_count >= 20'(PULSE_CYCLES - 1));
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			low_flag <= 1'b0;
			flag_d   <= 1'b0;
		end else begin
			low_flag <= next_flag;
			flag_d   <= low_flag;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			lvd_reset_req <= 1'b0;
			lvd_irq       <= 1'b0;
		end else begin
			lvd_reset_req <= ctrl.mode && low_flag;
			lvd_irq       <= !ctrl.mode && (low_flag != flag_d);
		end
	end

	always_comb begin
		read_word                      = 8'h00;
		read_word[lvd_pkg::ENABLE_BIT] = ctrl.enable;
		read_word[lvd_pkg::SELECT_BIT] = ctrl.select;
		read_word[lvd_pkg::MODE_BIT]   = ctrl.mode;
		read_word[lvd_pkg::FLAG_BIT]   = low_flag;
	end

	always_ff @(posedge mclk) begin
		if (rst)
			rdata <= 8'h00;
		else if (ctrl_hit_rd)
			rdata <= read_word;
		else
			rdata <= 8'h00;
	end

	chk_flag_off_zero: assert property (
		@(posedge mclk) disable iff (rst)
		!ctrl.enable |=> !low_flag)
		else $error("flag set while disabled");

	chk_flag_clears_high: assert property (
		@(posedge mclk) disable iff (rst)
		!sel_low |=> !low_flag)
		else $error("flag kept while input high");

	chk_flag_needs_low: assert property (
		@(posedge mclk) disable iff (rst)
		$rose(low_flag) |-> $past(sel_low))
		else $error("flag rose without low input");

	chk_reset_follows: assert property (
		@(posedge mclk) disable iff (rst)
		(ctrl.mode && low_flag) |=> lvd_reset_req)
		else $error("reset not raised");

	chk_reset_release: assert property (
		@(posedge mclk) disable iff (rst)
		!low_flag |=> !lvd_reset_req)
		else $error("reset not released");

	chk_reset_mode_only: assert property (
		@(posedge mclk) disable iff (rst)
		!ctrl.mode |=> !lvd_reset_req)
		else $error("reset raised in interrupt mode");

	// A reset clears flag and delay alike, so it is no crossing
	chk_irq_on_cross: assert property (
		@(posedge mclk) disable iff (rst)
		(!ctrl.mode && $changed(low_flag) && !$past(rst)) |=> lvd_irq)
		else $error("crossing interrupt missing");

	chk_irq_mode_only: assert property (
		@(posedge mclk) disable iff (rst)
		ctrl.mode |=> !lvd_irq)
		else $error("interrupt raised in reset mode");

	chk_mode_write: assert property (
		@(posedge mclk) disable iff (rst)
		ctrl_hit_wr |=> ctrl.mode == $past(wdata[lvd_pkg::MODE_BIT]))
		else $error("mode write lost");

	chk_filter_hold: assert property (
		@(posedge mclk) disable iff (rst)
		$rose(low_flag) |-> $past(low_count) >= 20'(PULSE_CYCLES - 1))
		else $error("flag set before pulse width");

	chk_count_clear: assert property (
		@(posedge mclk) disable iff (rst)
		!sel_low |=> low_count == 20'h00000)
		else $error("pulse counter not cleared");

	chk_count_bounded: assert property (
		@(posedge mclk) disable iff (rst)
		low_count <= 20'(PULSE_CYCLES))
		else $error("pulse counter overran");

	chk_reserved_zero: assert property (
		@(posedge mclk) disable iff (rst)
		rdata[6:3] == 4'h0)
		else $error("reserved bits nonzero");

	chk_clear_reset: assert property (
		@(posedge mclk)
		(rst && !detector_reset) |=> (ctrl == '0))
		else $error("control not cleared");

	chk_keep_on_detector: assert property (
		@(posedge mclk)
		(rst && detector_reset) |=> $stable(ctrl))
		else $error("control lost on detector reset");

	chk_enable_write: assert property (
		@(posedge mclk) disable iff (rst)
		ctrl_hit_wr |=> comparator_on == $past(wdata[lvd_pkg::ENABLE_BIT]))
		else $error("enable write lost");

	chk_select_write: assert property (
		@(posedge mclk) disable iff (rst)
		ctrl_hit_wr |=> source_select == $past(wdata[lvd_pkg::SELECT_BIT]))
		else $error("select write lost");

	chk_flag_readonly: assert property (
		@(posedge mclk) disable iff (rst)
		ctrl_hit_rd |=> rdata[0] == $past(low_flag))
		else $error("flag readback wrong");

	// Two clean edges are needed before the chain holds real data
	chk_sync_supply_path: assert property (
		@(posedge mclk) disable iff (rst)
		(!$past(rst) && !$past(rst, 2)) |->
		sync_supply[1] == $past(supply_low, 2))
		else $error("supply synchroniser delay wrong");

	chk_sync_pin_path: assert property (
		@(posedge mclk) disable iff (rst)
		(!$past(rst) && !$past(rst, 2)) |->
		sync_pin[1] == $past(pin_low, 2))
		else $error("pin synchroniser delay wrong");
endmodule : low_voltage_detect_control

// ==== lvd_comparator_model.sv ====
module lvd_comparator_model (
	// Clock and control
	input  wire logic mclk,
	input  wire logic comparator_on,
	// Analog levels
	input  wire logic vdd_below,
	input  wire logic ext_below,
	// Comparator outputs
	output logic      supply_low,
	output logic      pin_low
);
	timeunit 1ns;
	timeprecision 1ps;
	// silent unless enabled
	// Both levels report at once, so the block must pick one
	always_ff @(posedge mclk) begin
		supply_low <= comparator_on & vdd_below;
		pin_low    <= comparator_on & ext_below;
	end
endmodule : lvd_comparator_model

// ==== tb_low_voltage_detect_control.sv ====
module tb_low_voltage_detect_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 0, rst = 1, detector_reset = 0, wr = 0, rd = 0;
	logic        vdd_below = 0, ext_below = 0;
	logic [15:0] addr = lvd_pkg::CTRL_ADDR;
	logic [7:0]  wdata = 8'h00, rdata;
	logic        comparator_on, source_select, supply_low, pin_low;
	logic        lvd_reset_req, lvd_irq;
	int          mismatches = 0, check_count = 0;
	low_voltage_detect_control #(.PULSE_CYCLES(8)) dut_u (.mclk(mclk),
		.rst(rst), .detector_reset(detector_reset), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.comparator_on(comparator_on), .source_select(source_select),
		.supply_low(supply_low), .pin_low(pin_low),
		.lvd_reset_req(lvd_reset_req), .lvd_irq(lvd_irq));
	lvd_comparator_model cmp_u (.mclk(mclk), .comparator_on(comparator_on),
		.vdd_below(vdd_below),
		.ext_below(ext_below), .supply_low(supply_low), .pin_low(pin_low));
	initial begin
		forever #5 mclk = ~mclk;
	end
	task report_and_stop;
		if (mismatches == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	task check(string name, logic [7:0] exp, logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task wreg(logic [7:0] d);
		@(posedge mclk);
		wr <= 1;
		wdata <= d;
		@(posedge mclk);
		wr <= 0;
	endtask : wreg
	task rreg(logic [15:0] a, logic [7:0] exp);
		@(posedge mclk);
		addr <= a;
		rd <= 1;
		@(posedge mclk);
		rd <= 0;
		addr <= lvd_pkg::CTRL_ADDR;
		#1 check("rdata", exp, rdata);
	endtask : rreg
	// Bounded wait, sampled off the edge so a one-cycle pulse is seen
	task automatic wait_for(string name, ref logic sig, input logic lvl);
		int i;
		i = 0;
		while (i < 40 && sig !== lvl) begin
			@(posedge mclk);
			#1;
			i++;
		end
		check(name, {7'h00, lvl}, {7'h00, sig});
		if (sig !== lvl)
			report_and_stop();
	endtask : wait_for
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 0;
		rreg(lvd_pkg::CTRL_ADDR, 8'h00);
		wreg(8'hFF);
		rreg(lvd_pkg::CTRL_ADDR, 8'h86);
		check("comparator_on", 8'h01, {7'h00, comparator_on});
		check("source_select", 8'h01, {7'h00, source_select});
		rreg(16'hFFBF, 8'h00);
		repeat (4) @(posedge mclk);
		ext_below <= 1;
		rreg(lvd_pkg::CTRL_ADDR, 8'h86);
		wait_for("lvd_reset_req", lvd_reset_req, 1'b1);
		rreg(lvd_pkg::CTRL_ADDR, 8'h87);
		ext_below <= 0;
		wait_for("lvd_reset_req", lvd_reset_req, 1'b0);
		@(posedge mclk);
		rst <= 1;
		detector_reset <= 1;
		@(posedge mclk);
		rst <= 0;
		detector_reset <= 0;
		rreg(lvd_pkg::CTRL_ADDR, 8'h86);
		wreg(8'h00);
		rreg(lvd_pkg::CTRL_ADDR, 8'h00);
		// Pin low while the supply is watched must not flag
		ext_below <= 1;
		wreg(8'h80);
		repeat (20) @(posedge mclk);
		rreg(lvd_pkg::CTRL_ADDR, 8'h80);
		check("source_select", 8'h00, {7'h00, source_select});
		vdd_below <= 1;
		wait_for("lvd_irq", lvd_irq, 1'b1);
		@(posedge mclk);
		#1 check("lvd_irq", 8'h00, {7'h00, lvd_irq});
		vdd_below <= 0;
		wait_for("lvd_irq", lvd_irq, 1'b1);
		report_and_stop();
	end
endmodule : tb_low_voltage_detect_control
